// ### verilog/iap_indirect_unit.sv
// Purpose: indirect data-memory addressing through three pointers
// Assumes: synchronous data memory, read data valid one cycle after the
//          read strobe; APB master on the same clock
// Notes:   one APB transfer at a time; virtual locations never store
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "iap_regs.svh"

module iap_indirect_unit #(
	parameter int AW = `IAP_APB_AW,
	parameter int PTR_W = `IAP_PTR_W,
	parameter int NUM_PTR = `IAP_NUM_PTR
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// data memory port
	output logic [PTR_W-1:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [7:0] mem_rdata
);

	// ****************************************************************
	// decoding helpers
	// ****************************************************************

	// location kind from a byte address
	function automatic iap_pkg::iap_loc_t decode_loc(
		input logic [AW-1:0] a
	);
		iap_pkg::iap_loc_t k;
		k = iap_pkg::IAP_LOC_NONE;
		if (a[AW-1:7] == '0 && a[1:0] == 2'h0 &&
			a[6:5] != `IAP_SHARED_IDX) begin
			case (a[4:0])
				`IAP_OFS_PLAIN: k = iap_pkg::IAP_LOC_PLAIN;
				`IAP_OFS_POST_INC: k = iap_pkg::IAP_LOC_POST_INC;
				`IAP_OFS_POST_DEC: k = iap_pkg::IAP_LOC_POST_DEC;
				`IAP_OFS_PRE_INC: k = iap_pkg::IAP_LOC_PRE_INC;
				`IAP_OFS_OFFSET: k = iap_pkg::IAP_LOC_OFFSET;
				`IAP_OFS_LOW: k = iap_pkg::IAP_LOC_LOW;
				`IAP_OFS_HIGH: k = iap_pkg::IAP_LOC_HIGH;
				default: k = iap_pkg::IAP_LOC_NONE;
			endcase
		end
		return k;
	endfunction

	// shared register select: 0 working, 1 bank, 2 last address, 3 none
	function automatic logic [1:0] decode_shared(input logic [AW-1:0] a);
		logic [1:0] s;
		s = 2'h3;
		if (a[AW-1:7] == '0 && a[1:0] == 2'h0 &&
			a[6:5] == `IAP_SHARED_IDX) begin
			case (a[4:0])
				`IAP_OFS_WORKING: s = 2'h0;
				`IAP_OFS_BANK: s = 2'h1;
				`IAP_OFS_LAST_ADDR: s = 2'h2;
				default: s = 2'h3;
			endcase
		end
		return s;
	endfunction

	// true for the five memory-redirecting locations
	function automatic logic is_virtual(input iap_pkg::iap_loc_t k);
		return (k == iap_pkg::IAP_LOC_PLAIN) ||
			(k == iap_pkg::IAP_LOC_POST_INC) ||
			(k == iap_pkg::IAP_LOC_POST_DEC) ||
			(k == iap_pkg::IAP_LOC_PRE_INC) ||
			(k == iap_pkg::IAP_LOC_OFFSET);
	endfunction

	// ****************************************************************
	// state and request registers
	// ****************************************************************
	iap_pkg::iap_state_t state_ff;
	iap_pkg::iap_state_t nxt_state;
	iap_pkg::iap_loc_t req_loc_ff;
	logic [1:0] req_ptr_ff;
	logic req_write_ff;
	logic [7:0] req_wdata_ff;
	logic [7:0] working_ff;
	logic [`IAP_HIGH_W-1:0] bank_ff;
	logic [PTR_W-1:0] last_addr_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [PTR_W-1:0] mem_addr_ff;
	logic [7:0] mem_wdata_ff;
	logic mem_we_ff;
	logic mem_re_ff;

	// decoded view of the bus
	iap_pkg::iap_loc_t bus_loc;
	logic [1:0] bus_ptr;
	logic [1:0] bus_shared;
	logic access;
	logic start;

	// pointer controls and values
	logic [NUM_PTR-1:0] ptr_wr_low;
	logic [NUM_PTR-1:0] ptr_wr_high;
	logic [NUM_PTR-1:0] ptr_inc;
	logic [NUM_PTR-1:0] ptr_dec;
	logic [PTR_W-1:0] ptr_val [0:NUM_PTR-1];
	logic [PTR_W-1:0] cur_ptr;
	logic [PTR_W-1:0] req_ptr_val;
	logic [PTR_W-1:0] offset_ext;
	logic [PTR_W-1:0] eff_addr;

	assign bus_loc = decode_loc(paddr);
	assign bus_ptr = paddr[6:5];
	assign bus_shared = decode_shared(paddr);
	assign access = psel && penable;
	assign start = access && (state_ff == iap_pkg::IAP_ST_IDLE);

	// ****************************************************************
	// pointer instances
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
			iap_pointer #(
				.PTR_W(PTR_W)
			) u_ptr (
				.clock(clock),
				.resetn(resetn),
				.wr_low(ptr_wr_low[gi]),
				.wr_high(ptr_wr_high[gi]),
				.wdata(pwdata[7:0]),
				.inc(ptr_inc[gi]),
				.dec(ptr_dec[gi]),
				.ptr_ff(ptr_val[gi])
			);

			// byte writes straight from the bus
			assign ptr_wr_low[gi] = start && pwrite &&
				bus_ptr == 2'(gi) && bus_loc == iap_pkg::IAP_LOC_LOW;
			assign ptr_wr_high[gi] = start && pwrite &&
				bus_ptr == 2'(gi) && bus_loc == iap_pkg::IAP_LOC_HIGH;

			// pre step on start, post step when the access completes
			assign ptr_inc[gi] = (start && bus_ptr == 2'(gi) &&
				bus_loc == iap_pkg::IAP_LOC_PRE_INC) || // [RULE_02]
				(state_ff == iap_pkg::IAP_ST_WAIT &&
				req_ptr_ff == 2'(gi) &&
				req_loc_ff == iap_pkg::IAP_LOC_POST_INC); // [RULE_06]
			assign ptr_dec[gi] = state_ff == iap_pkg::IAP_ST_WAIT &&
				req_ptr_ff == 2'(gi) &&
				req_loc_ff == iap_pkg::IAP_LOC_POST_DEC; // [RULE_03]
		end
	endgenerate

	// ****************************************************************
	// address forming
	// ****************************************************************
	// working register is a signed offset, sign extended to pointer width
	assign offset_ext = {{(PTR_W-8){working_ff[7]}}, working_ff};

	// pointer that the bus is addressing, shared block reads as zero
	always_comb begin
		cur_ptr = '0;
		req_ptr_val = '0;
		if (bus_ptr != `IAP_SHARED_IDX) begin
			cur_ptr = ptr_val[bus_ptr];
		end
		if (req_ptr_ff != `IAP_SHARED_IDX) begin
			req_ptr_val = ptr_val[req_ptr_ff];
		end
	end

	// pointer as address, plus working register for the offset location
	always_comb begin
		eff_addr = cur_ptr; // [RULE_01] [RULE_03] [RULE_06]
		if (bus_loc == iap_pkg::IAP_LOC_OFFSET) begin
			eff_addr = cur_ptr + offset_ext; // [RULE_04]
		end
	end

	// ****************************************************************
	// controller
	// ****************************************************************
	// next state: memory accesses take the long path
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			iap_pkg::IAP_ST_IDLE: begin
				if (start && is_virtual(bus_loc)) begin
					if (bus_loc == iap_pkg::IAP_LOC_PRE_INC) begin
						nxt_state = iap_pkg::IAP_ST_PRE; // [RULE_02]
					end else begin
						nxt_state = iap_pkg::IAP_ST_MEM;
					end
				end else if (start) begin
					nxt_state = iap_pkg::IAP_ST_DONE;
				end
			end
			iap_pkg::IAP_ST_PRE: nxt_state = iap_pkg::IAP_ST_MEM;
			iap_pkg::IAP_ST_MEM: nxt_state = iap_pkg::IAP_ST_WAIT;
			iap_pkg::IAP_ST_WAIT: nxt_state = iap_pkg::IAP_ST_DONE;
			iap_pkg::IAP_ST_DONE: nxt_state = iap_pkg::IAP_ST_IDLE;
			default: nxt_state = iap_pkg::IAP_ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_ff <= iap_pkg::IAP_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// request capture at the start of a transfer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			req_loc_ff <= iap_pkg::IAP_LOC_NONE;
			req_ptr_ff <= 2'h0;
			req_write_ff <= 1'b0;
			req_wdata_ff <= 8'h00;
		end else if (start) begin
			req_loc_ff <= bus_loc;
			req_ptr_ff <= bus_ptr;
			req_write_ff <= pwrite;
			req_wdata_ff <= pwdata[7:0];
		end
	end

	// ****************************************************************
	// data memory port
	// ****************************************************************
	// strobes stand for exactly one cycle; nothing is stored locally
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_addr_ff <= '0;
			mem_wdata_ff <= 8'h00;
			mem_we_ff <= 1'b0;
			mem_re_ff <= 1'b0;
		end else if (start && is_virtual(bus_loc) &&
			bus_loc != iap_pkg::IAP_LOC_PRE_INC) begin
			mem_addr_ff <= eff_addr; // [RULE_01] [RULE_04]
			mem_wdata_ff <= pwdata[7:0]; // [RULE_05]
			mem_we_ff <= pwrite; // [RULE_05]
			mem_re_ff <= !pwrite; // [RULE_05]
		end else if (state_ff == iap_pkg::IAP_ST_PRE) begin
			mem_addr_ff <= req_ptr_val; // [RULE_02]
			mem_wdata_ff <= req_wdata_ff;
			mem_we_ff <= req_write_ff;
			mem_re_ff <= !req_write_ff;
		end else begin
			mem_we_ff <= 1'b0;
			mem_re_ff <= 1'b0;
		end
	end

	// last memory address used, for software to inspect
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			last_addr_ff <= '0;
		end else if (state_ff == iap_pkg::IAP_ST_MEM) begin
			last_addr_ff <= mem_addr_ff;
		end
	end

	// ****************************************************************
	// shared registers
	// ****************************************************************
	// working register and bank selector, software written
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			working_ff <= `IAP_RST_WORKING;
			bank_ff <= `IAP_RST_BANK;
		end else if (start && pwrite && bus_shared == 2'h0) begin
			working_ff <= pwdata[7:0];
		end else if (start && pwrite && bus_shared == 2'h1) begin
			bank_ff <= pwdata[`IAP_HIGH_W-1:0];
		end
	end

	// ****************************************************************
	// apb answer
	// ****************************************************************
	// ready for one cycle; memory reads take data in the wait state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			if (start && !is_virtual(bus_loc)) begin
				pready_ff <= 1'b1;
				prdata_ff <= 32'h0000_0000;
				if (bus_loc == iap_pkg::IAP_LOC_LOW) begin
					prdata_ff[7:0] <= cur_ptr[7:0];
				end else if (bus_loc == iap_pkg::IAP_LOC_HIGH) begin
					prdata_ff[PTR_W-9:0] <= cur_ptr[PTR_W-1:8];
				end else if (bus_shared == 2'h0) begin
					prdata_ff[7:0] <= working_ff;
				end else if (bus_shared == 2'h1) begin
					prdata_ff[`IAP_HIGH_W-1:0] <= bank_ff;
				end else if (bus_shared == 2'h2) begin
					prdata_ff[PTR_W-1:0] <= last_addr_ff;
				end else begin
					pslverr_ff <= 1'b1; // unmapped address
				end
			end else if (state_ff == iap_pkg::IAP_ST_WAIT) begin
				pready_ff <= 1'b1;
				prdata_ff <= 32'h0000_0000;
				if (!req_write_ff) begin
					prdata_ff[7:0] <= mem_rdata; // [RULE_05]
				end
			end
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata = prdata_ff;
	assign mem_addr = mem_addr_ff;
	assign mem_wdata = mem_wdata_ff;
	assign mem_we = mem_we_ff;
	assign mem_re = mem_re_ff;

endmodule

// ### shared/iap_regs.svh
// Purpose: offsets, field positions, reset values and widths of the
//          indirect addressing pointer unit
// Assumes: APB byte addressing, every register one aligned 32-bit word
// Notes:   definitions only, no logic
//
// Overview of operation
// [RULE_01] any virtual location access except offset drives its pointer onto the memory address
// [RULE_02] pre-increment location bumps the pointer first, then accesses memory
// [RULE_03] post-decrement location accesses memory, then subtracts one from pointer
// [RULE_04] offset location addresses memory at pointer plus working register
// [RULE_05] virtual locations hold no storage; reads and writes go to memory
// [RULE_06] plain location keeps pointer; post-increment accesses then adds one
`ifndef IAP_REGS_SVH
`define IAP_REGS_SVH

// ****************************************************************
// bus and field widths
// ****************************************************************
`define IAP_APB_AW 8
`define IAP_DATA_W 8
`define IAP_PTR_W 12
`define IAP_HIGH_W 4
`define IAP_NUM_PTR 3

// ****************************************************************
// per-pointer block: base is pointer index times the stride
// ****************************************************************
`define IAP_PTR_STRIDE 8'h20
`define IAP_OFS_PLAIN 5'h00
`define IAP_OFS_POST_INC 5'h04
`define IAP_OFS_POST_DEC 5'h08
`define IAP_OFS_PRE_INC 5'h0C
`define IAP_OFS_OFFSET 5'h10
`define IAP_OFS_LOW 5'h14
`define IAP_OFS_HIGH 5'h18

// ****************************************************************
// shared block (pointer index field = 3)
// ****************************************************************
`define IAP_SHARED_IDX 2'h3
`define IAP_OFS_WORKING 5'h00
`define IAP_OFS_BANK 5'h04
`define IAP_OFS_LAST_ADDR 5'h08

// ****************************************************************
// reset values
// ****************************************************************
`define IAP_RST_LOW 8'h00
`define IAP_RST_HIGH 4'h0
`define IAP_RST_WORKING 8'h00
`define IAP_RST_BANK 4'h0

`endif

// ### shared/iap_pkg.sv
// Purpose: types of the indirect addressing pointer unit
// Assumes: constants live in iap_regs.svh
// Notes:   nothing here is imported; users write iap_pkg::name
package iap_pkg;

	// ****************************************************************
	// controller states
	// ****************************************************************
	typedef enum logic [2:0] {
		IAP_ST_IDLE = 3'b000,
		IAP_ST_PRE = 3'b001,
		IAP_ST_MEM = 3'b010,
		IAP_ST_WAIT = 3'b011,
		IAP_ST_DONE = 3'b100
	} iap_state_t;

	// ****************************************************************
	// kinds of location inside a pointer block
	// ****************************************************************
	typedef enum logic [2:0] {
		IAP_LOC_PLAIN = 3'b000,
		IAP_LOC_POST_INC = 3'b001,
		IAP_LOC_POST_DEC = 3'b010,
		IAP_LOC_PRE_INC = 3'b011,
		IAP_LOC_OFFSET = 3'b100,
		IAP_LOC_LOW = 3'b101,
		IAP_LOC_HIGH = 3'b110,
		IAP_LOC_NONE = 3'b111
	} iap_loc_t;

endpackage

// ### verilog/iap_pointer.sv
// Purpose: one indirect pointer, low byte plus high nibble
// Assumes: at most one of the controls is active in any cycle
// Notes:   increment and decrement wrap around the full pointer width
`timescale 1ns/100ps
`include "iap_regs.svh"

module iap_pointer #(
	parameter int PTR_W = `IAP_PTR_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// controls
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [7:0] wdata,
	input wire logic inc,
	input wire logic dec,
	// pointer value
	output logic [PTR_W-1:0] ptr_ff
);

	// ****************************************************************
	// pointer register
	// ****************************************************************
	// byte writes, or a step of one up or down
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ptr_ff <= {`IAP_RST_HIGH, `IAP_RST_LOW};
		end else if (wr_low) begin
			ptr_ff[7:0] <= wdata;
		end else if (wr_high) begin
			ptr_ff[PTR_W-1:8] <= wdata[PTR_W-9:0];
		end else if (inc) begin
			ptr_ff <= ptr_ff + {{(PTR_W-1){1'b0}}, 1'b1}; // [RULE_02]
		end else if (dec) begin
			ptr_ff <= ptr_ff - {{(PTR_W-1){1'b0}}, 1'b1}; // [RULE_03]
		end
	end

endmodule

// ### bench/iap_data_mem.sv
// Purpose: data memory seen by the indirect addressing unit
// Assumes: read data valid in the cycle after the read strobe
// Notes: read bus shows inverted junk outside the valid cycle
`timescale 1ns/100ps

module iap_data_mem (
	// clock
	input wire logic clock,
	// access port
	input wire logic [11:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:4095];

	initial mem_rdata = 8'h00;

	// byte store, one-cycle read data then garbage
	always @(posedge clock) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		if (mem_re)
			mem_rdata <= mem[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule

// ### bench/iap_indirect_unit_sva.sv
// Purpose: port checks of the indirect addressing unit
// Assumes: apb request held until pready
// Notes: bound into every iap_indirect_unit
`timescale 1ns/100ps

module iap_chk #(
	parameter int AW = 8,
	parameter int PTR_W = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// memory port
	input wire logic [PTR_W-1:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [7:0] mem_rdata
);
	// ****
	// address decode
	// ****
	logic ok, virt, pre, regs, stb;
	assign ok = paddr[7:5] < 3'h3 && paddr[1:0] == 2'h0;
	assign virt = ok && paddr[4:0] <= 5'h10;
	assign pre = virt && paddr[4:0] == 5'h0C;
	assign regs = ok && (paddr[4:0] == 5'h14 || paddr[4:0] == 5'h18);
	assign stb = mem_re || mem_we;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property read_back;
		logic [7:0] v;
		mem_re |-> ##1 (1, v = mem_rdata)
			##1 (pready && prdata == {24'h0, v});
	endproperty

	// ****
	// assertions
	// ****
	a_prompt_strobe: assert property (
		psel && $rose(penable) && virt && !pre |-> ##1 stb)
		else $error("virtual access without memory strobe");
	a_pre_bump_first: assert property (
		psel && $rose(penable) && pre |-> ##1 !stb ##1 stb)
		else $error("pre-increment strobe timing wrong");
	a_write_passes: assert property (
		psel && $rose(penable) && virt && pwrite
		|-> ##[1:2] (mem_we && mem_wdata == pwdata[7:0]))
		else $error("virtual write not passed to memory");
	a_read_returns: assert property (read_back)
		else $error("memory read data not returned");
	a_reg_no_mem: assert property (
		psel && $rose(penable) && regs |-> ##1 (pready && !stb))
		else $error("pointer register access touched memory");
	a_addr_holds: assert property (
		stb |=> (!stb && $stable(mem_addr)) [*2])
		else $error("memory address or strobe unstable");
	a_err_reads_zero: assert property (
		pslverr |-> pready && prdata == 32'h0 && !stb)
		else $error("error response malformed");

	c_pre: cover property (psel && $rose(penable) && pre);
	c_rd: cover property (mem_re ##2 pready);
	c_err: cover property (pslverr);
endmodule

bind iap_indirect_unit iap_chk #(.AW(AW), .PTR_W(PTR_W)) chk (.clock(clock),
	.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));

// ### bench/tb_indirect_addressing_pointers.sv
// Purpose: self-checking bench of the indirect addressing unit
// Assumes: register map of the unit, memory model as far side
// Notes: memory contents checked through the model's array
`timescale 1ns/100ps

module tb_indirect_addressing_pointers;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, mem_we, mem_re;
	logic [11:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata;
	int err_count = 0;
	int n_compared = 0;

	always #25 clock = ~clock;

	iap_indirect_unit uut (.clock(clock), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.mem_re(mem_re), .mem_rdata(mem_rdata));
	iap_data_mem mem_model (.clock(clock), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
		.mem_rdata(mem_rdata));

	// ****
	// helpers
	// ****
	task finish_test;
		if (err_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task bad(input string m);
		err_count++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x, input string m);
		n_compared++;
		if (g !== x) bad(m);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) bad("no pready");
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic x);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk({31'h0, e}, {31'h0, x}, "slave error flag");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		chk(r, x, "read data");
	endtask
	task setp(input logic [7:0] b, input logic [11:0] p);
		wr(b + 8'h14, p[7:0], 1'b0);
		wr(b + 8'h18, {4'h0, p[11:8]}, 1'b0);
	endtask
	task chkp(input logic [7:0] b, input logic [11:0] p);
		rd(b + 8'h14, {24'h0, p[7:0]});
		rd(b + 8'h18, {28'h0, p[11:8]});
	endtask
	task chkm(input logic [11:0] a, input logic [7:0] x);
		chk({24'h0, mem_model.mem[a]}, {24'h0, x}, "memory byte");
	endtask

	// ****
	// scenarios
	// ****
	task t_reset;
		for (int i = 0; i < 3; i++)
			chkp(8'(i * 32), 12'h000);
		rd(8'h60, 32'h0);
		rd(8'h64, 32'h0);
		rd(8'h68, 32'h0);
		wr(8'h64, 8'hA7, 1'b0);
		rd(8'h64, 32'h7);
	endtask
	task t_plain;
		setp(8'h20, 12'h3FF);
		wr(8'h20, 8'h5A, 1'b0);
		chkm(12'h3FF, 8'h5A);
		rd(8'h20, 32'h5A);
		chkp(8'h20, 12'h3FF);
	endtask
	task t_post_increment_location;
		mem_model.mem[0] = 8'hA5;
		setp(8'h00, 12'hFFF);
		wr(8'h04, 8'hC3, 1'b0);
		chkm(12'hFFF, 8'hC3);
		rd(8'h68, 32'hFFF);
		rd(8'h04, 32'hA5);
		chkp(8'h00, 12'h001);
	endtask
	task t_post_decrement_location;
		setp(8'h40, 12'h000);
		rd(8'h48, 32'hA5);
		chkp(8'h40, 12'hFFF);
		wr(8'h48, 8'h3C, 1'b0);
		chkm(12'hFFF, 8'h3C);
		chkp(8'h40, 12'hFFE);
	endtask
	task t_pre_increment_location;
		mem_model.mem[12'h101] = 8'h11;
		setp(8'h20, 12'h0FF);
		wr(8'h2C, 8'h77, 1'b0);
		chkm(12'h100, 8'h77);
		rd(8'h2C, 32'h11);
		chkp(8'h20, 12'h101);
	endtask
	task t_offset;
		mem_model.mem[12'h404] = 8'h66;
		setp(8'h40, 12'h3FF);
		wr(8'h60, 8'h05, 1'b0);
		rd(8'h50, 32'h66);
		wr(8'h60, 8'hFE, 1'b0);
		wr(8'h50, 8'h99, 1'b0);
		chkm(12'h3FD, 8'h99);
		chkp(8'h40, 12'h3FF);
	endtask
	task t_unmapped;
		logic [31:0] r;
		logic e;
		apb(1'b0, 8'h80, 8'h00, r, e);
		chk({e, r[30:0]}, 32'h80000000, "unmapped read");
		wr(8'h1C, 8'h12, 1'b1);
	endtask
	// reset in mid-run: pointer 2, working and bank back to zero
	task t_rerun;
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		chkp(8'h40, 12'h000);
		rd(8'h60, 32'h0);
		rd(8'h64, 32'h0);
		rd(8'h68, 32'h0);
		rd(8'h40, 32'hA5);
	endtask

	// ****
	// main sequence and watchdog
	// ****
	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		t_reset;
		t_plain;
		t_post_increment_location;
		t_post_decrement_location;
		t_pre_increment_location;
		t_offset;
		t_unmapped;
		t_rerun;
		finish_test;
	end
	initial begin
		#1000000;
		bad("timeout");
		finish_test;
	end
endmodule
